// ==== pkg/ddrrf_map.svh ====
/*
  Offsets, field positions, reset values and timing counts of the
  DDR2 refresh and burst command block.
  Assumes a 100 MHz core clock; included by bare name after the package.
*/
`ifndef DDRRF_MAP_SVH
`define DDRRF_MAP_SVH

// register byte offsets (low address byte)
`define DDRRF_OFF_CTRL    8'h00
`define DDRRF_OFF_STATUS  8'h04
`define DDRRF_OFF_REFCNT  8'h08

// control fields
`define DDRRF_CTRL_BL_MSB 2
`define DDRRF_CTRL_BL_LSB 0
`define DDRRF_CTRL_BT_BIT 3
`define DDRRF_CTRL_CL_MSB 6
`define DDRRF_CTRL_CL_LSB 4
`define DDRRF_CTRL_AL_MSB 10
`define DDRRF_CTRL_AL_LSB 8
`define DDRRF_CTRL_W      11
`define DDRRF_CTRL_MASK   11'h77f
`define DDRRF_CTRL_RESET  11'h032
`define DDRRF_BL_EIGHT    3'h3
`define DDRRF_AL_MAX      3'h6
`define DDRRF_CL_MIN      3'h2

// status fields
`define DDRRF_ST_SREF_BIT 0
`define DDRRF_ST_EXIT_BIT 1
`define DDRRF_ST_DLL_BIT  2
`define DDRRF_ST_IDLE_BIT 3
`define DDRRF_ST_BUSY_BIT 4

// timing
`define DDRRF_CLK_MHZ     100
`define DDRRF_TRFC_NS     105
`define DDRRF_TXSNR_NS    115
`define DDRRF_TREFI_NS    7800
`define DDRRF_TRFC_CYC    ((`DDRRF_TRFC_NS * `DDRRF_CLK_MHZ + 999) / 1000)
`define DDRRF_TXSNR_CYC   ((`DDRRF_TXSNR_NS * `DDRRF_CLK_MHZ + 999) / 1000)
`define DDRRF_TREFI_CYC   ((`DDRRF_TREFI_NS * `DDRRF_CLK_MHZ) / 1000)
`define DDRRF_LINE_DEPTH  16

`endif

// ==== pkg/ddrrf_pkg.sv ====
/*
  Types and shared functions of the DDR2 refresh and burst command block.
  Assumes nothing of its surroundings.
*/
package ddrrf_pkg;

   typedef enum {ST_RUN, ST_SREF, ST_EXIT} ddrrf_state_t;

   typedef enum {C_DESEL, C_NOP, C_ACT, C_RD, C_WR, C_PRE, C_REF, C_SRE, C_MRS} ddrrf_kind_t;

   // command pins as sampled on the rising edge
   typedef struct packed {
      logic        cs_n;
      logic        ras_n;
      logic        cas_n;
      logic        we_n;
      logic        cke;
      logic        odt;
      logic [1:0]  ba;
      logic [12:0] addr;
   } ddrrf_cmd_t;

   // one posted column command waiting in the latency line
   typedef struct packed {
      logic       valid;
      logic       wr;
      logic [8:0] col;
   } ddrrf_ent_t;

   // command decode; cke low only ever means self refresh entry or nothing
   function automatic ddrrf_kind_t ddrrf_decode(input ddrrf_cmd_t c);
      ddrrf_kind_t k;
      k = C_DESEL;
      if (!c.cke) begin
         if ({c.cs_n, c.ras_n, c.cas_n, c.we_n} == 4'h1) begin
            k = C_SRE;
         end
      end else if (!c.cs_n) begin
         case ({c.ras_n, c.cas_n, c.we_n})
            3'h7:    k = C_NOP;
            3'h3:    k = C_ACT;
            3'h5:    k = C_RD;
            3'h4:    k = C_WR;
            3'h2:    k = C_PRE;
            3'h1:    k = C_REF;
            3'h0:    k = C_MRS;
            default: k = C_NOP;
         endcase
      end
      return k;
   endfunction

   // column of beat i; upper bits never change so the burst stays in its segment
   function automatic logic [8:0] ddrrf_beat_col(input logic [8:0] s,
                                                 input logic [2:0] i,
                                                 input logic       bl8,
                                                 input logic       ilv);
      logic [1:0] lo;
      logic       b2;
      lo = ilv ? (s[1:0] ^ i[1:0]) : 2'(s[1:0] + i[1:0]);
      b2 = bl8 ? (s[2] ^ i[2]) : s[2];
      return {s[8:3], b2, lo};
   endfunction

endpackage

// ==== src/ddrrf_colseq.sv ====
/*
  Burst column sequencer: two beat addresses per clock, four or eight beats.
  Assumes start pulses come at least two clocks apart.
*/
`timescale 1ns/100ps
`default_nettype none
`include "ddrrf_map.svh"

module ddrrf_colseq
   import ddrrf_pkg::*;
(
   input  wire logic       hclk,
   input  wire logic       hresetn,
   input  wire logic       start,
   input  wire logic       start_wr,
   input  wire logic [8:0] start_col,
   input  wire logic       bl8,
   input  wire logic       ilv,
   output logic            beat_valid,
   output logic            beat_wr,
   output logic [8:0]      beat_col0,
   output logic [8:0]      beat_col1
);

   logic       valid_reg, valid_next;
   logic       wr_reg,    wr_next;
   logic       bl8_reg,   bl8_next;
   logic       ilv_reg,   ilv_next;
   logic [1:0] pair_reg,  pair_next;
   logic [8:0] base_reg,  base_next;
   logic [8:0] col0_reg,  col0_next;
   logic [8:0] col1_reg,  col1_next;
   logic [1:0] last_pair;

   assign last_pair = bl8_reg ? 2'h3 : 2'h1;

   // a new start wins over a running burst, which is how a bl8 interrupt lands
   always_comb begin
      valid_next = 1'b0;
      wr_next    = wr_reg;
      bl8_next   = bl8_reg;
      ilv_next   = ilv_reg;
      pair_next  = pair_reg;
      base_next  = base_reg;
      col0_next  = col0_reg;
      col1_next  = col1_reg;
      if (start) begin
         valid_next = 1'b1;
         wr_next    = start_wr;
         bl8_next   = bl8;
         ilv_next   = ilv;
         pair_next  = 2'h0;
         base_next  = start_col;
         col0_next  = ddrrf_beat_col(start_col, 3'h0, bl8, ilv); // [R22]
         col1_next  = ddrrf_beat_col(start_col, 3'h1, bl8, ilv); // [R22]
      end else if (valid_reg && pair_reg != last_pair) begin // [R21]
         valid_next = 1'b1;
         pair_next  = 2'(pair_reg + 2'h1);
         col0_next  = ddrrf_beat_col(base_reg, {pair_next, 1'b0}, bl8_reg, ilv_reg); // [R15]
         col1_next  = ddrrf_beat_col(base_reg, {pair_next, 1'b1}, bl8_reg, ilv_reg); // [R15]
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         valid_reg <= 1'b0;
         wr_reg    <= 1'b0;
         bl8_reg   <= 1'b0;
         ilv_reg   <= 1'b0;
         pair_reg  <= 2'h0;
         base_reg  <= 9'h000;
         col0_reg  <= 9'h000;
         col1_reg  <= 9'h000;
      end else begin
         valid_reg <= valid_next;
         wr_reg    <= wr_next;
         bl8_reg   <= bl8_next;
         ilv_reg   <= ilv_next;
         pair_reg  <= pair_next;
         base_reg  <= base_next;
         col0_reg  <= col0_next;
         col1_reg  <= col1_next;
      end
   end

   assign beat_valid = valid_reg;
   assign beat_wr    = wr_reg;
   assign beat_col0  = col0_reg;
   assign beat_col1  = col1_reg;

   a_beat_segment: assert property (@(posedge hclk) disable iff (!hresetn) // [R15]
      valid_reg |-> (col0_reg[8:3] == base_reg[8:3] && col1_reg[8:3] == base_reg[8:3] &&
                     (bl8_reg || (col0_reg[2] == base_reg[2] && col1_reg[2] == base_reg[2]))))
      else $error("burst left its page segment");

   a_bl4_length: assert property (@(posedge hclk) disable iff (!hresetn) // [R21]
      (start && !bl8) ##1 !start ##1 !start |=> !valid_reg)
      else $error("four beat burst ran past two clocks");

   a_seq_order: assert property (@(posedge hclk) disable iff (!hresetn) // [R22]
      (start && !ilv && !bl8 && start_col[1:0] == 2'h1) |=>
         (col0_reg[1:0] == 2'h1 && col1_reg[1:0] == 2'h2) ##1 (col0_reg[1:0] == 2'h3))
      else $error("sequential order wrong");

endmodule

`default_nettype wire

// ==== src/ddrrf_top.sv ====
/*
  DDR2 command core: self refresh, auto refresh, deselect and nop handling,
  posted column commands and burst sequencing, with an AHB-Lite register slave.
  Assumes command pins synchronous to hclk and single word AHB transfers.
*/
// Behaviour
// R1: in self refresh only cke is watched; low cke keeps the device there.
// R2: controller turns termination off before self refresh entry.
// R3: dll goes off on self refresh entry and back on at exit, unprompted.
// R4: controller may stop the clock after entry, restarting it before exit.
// R5: exit is cke rising with deselect or nop, clock already stable.
// R6: controller waits the non-read exit delay before any valid command.
// R7: controller gives nop or deselect every edge of that exit interval.
// R8: controller keeps cke high through the read exit period, termination off.
// R9: one auto refresh after exit before self refresh may be re-entered.
// R10: refresh ignores bank and address; all banks idle when it completes.
// R11: controller issues every refresh itself within the average interval.
// R12: controller waits the refresh cycle time before activate or refresh.
// R13: up to eight refreshes may be postponed; gap at most nine intervals.
// R14: deselect and nop change no state; strobes and address ignored.
// R15: bursts stay in their aligned four or eight column segment.
// R16: controller interrupts only bl8, same direction, at the four beat mark.
// R17: controller spaces column commands at least two clocks apart.
// R18: column commands taken any time, held for additive latency.
// R19: read latency is additive plus cas latency; write latency one less.
// R20: early column commands need nonzero additive latency programmed.
// R21: four and eight beat bursts only; length and type set by mode bits.
// R22: interleave is start xor beat; sequential wraps inside each nibble.
// R23: additive latency settings zero through six are supported.
// R24: commands decoded each edge from the strobes, cke picks self refresh.
`timescale 1ns/100ps
`default_nettype none
`include "ddrrf_map.svh"

module ddrrf_top
   import ddrrf_pkg::*;
(
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   input  wire ddrrf_cmd_t  cmd,
   output logic             self_refresh,
   output logic             dll_on,
   output logic             refresh_busy,
   output logic             banks_idle,
   output logic             odt_active,
   output logic             beat_valid,
   output logic             beat_wr,
   output logic [8:0]       beat_col0,
   output logic [8:0]       beat_col1
);

   localparam int RFC_A = `DDRRF_TRFC_CYC + 1;

   ddrrf_kind_t kind;
   assign kind = ddrrf_decode(cmd); // [R24]

   // bus slave state
   logic [`DDRRF_CTRL_W-1:0] ctrl_reg,  ctrl_next;
   logic                     wpend_reg, wpend_next;
   logic [7:0]               waddr_reg, waddr_next;
   logic [31:0]              rdata_reg, rdata_next;
   logic [4:0]               status;

   // refresh and self refresh state
   ddrrf_state_t state_reg, state_next;
   logic         dll_reg,   dll_next;
   logic         idle_reg,  idle_next;
   logic [7:0]   rfc_reg,   rfc_next;
   logic [7:0]   xsnr_reg,  xsnr_next;
   logic [11:0]  trefi_reg, trefi_next;
   logic [15:0]  refc_reg,  refc_next;
   logic [15:0]  selfc_reg, selfc_next;

   // posted column line
   ddrrf_ent_t line_reg [`DDRRF_LINE_DEPTH];
   ddrrf_ent_t line_next [`DDRRF_LINE_DEPTH];

   // configuration as used by the logic; reserved codes are clamped
   logic [2:0] cfg_al;
   logic [2:0] cfg_cl;
   logic [3:0] cfg_rl;
   logic       cfg_bl8;
   logic       cfg_ilv;
   assign cfg_al  = (ctrl_reg[`DDRRF_CTRL_AL_MSB:`DDRRF_CTRL_AL_LSB] > `DDRRF_AL_MAX) ?
                    `DDRRF_AL_MAX : ctrl_reg[`DDRRF_CTRL_AL_MSB:`DDRRF_CTRL_AL_LSB]; // [R23]
   assign cfg_cl  = (ctrl_reg[`DDRRF_CTRL_CL_MSB:`DDRRF_CTRL_CL_LSB] < `DDRRF_CL_MIN) ?
                    `DDRRF_CL_MIN : ctrl_reg[`DDRRF_CTRL_CL_MSB:`DDRRF_CTRL_CL_LSB];
   assign cfg_rl  = 4'(cfg_al + cfg_cl); // [R19]
   assign cfg_bl8 = ctrl_reg[`DDRRF_CTRL_BL_MSB:`DDRRF_CTRL_BL_LSB] == `DDRRF_BL_EIGHT; // [R21]
   assign cfg_ilv = ctrl_reg[`DDRRF_CTRL_BT_BIT]; // [R21]

   assign status = {rfc_reg != 8'h00, idle_reg, dll_reg,
                    state_reg == ST_EXIT, state_reg == ST_SREF};

   // ahb-lite: zero wait, read data latched in the address phase
   always_comb begin
      logic acc;
      acc        = hsel && htrans[1] && hready;
      ctrl_next  = ctrl_reg;
      wpend_next = acc && hwrite;
      waddr_next = acc ? haddr[7:0] : waddr_reg;
      rdata_next = rdata_reg;
      if (wpend_reg && waddr_reg == `DDRRF_OFF_CTRL) begin
         ctrl_next = hwdata[`DDRRF_CTRL_W-1:0] & `DDRRF_CTRL_MASK;
      end
      if (acc && !hwrite) begin
         case (haddr[7:0])
            `DDRRF_OFF_CTRL:   rdata_next = {21'h000000, ctrl_next};
            `DDRRF_OFF_STATUS: rdata_next = {27'h0000000, status};
            `DDRRF_OFF_REFCNT: rdata_next = {selfc_reg, refc_reg};
            default:           rdata_next = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_reg  <= `DDRRF_CTRL_RESET;
         wpend_reg <= 1'b0;
         waddr_reg <= 8'h00;
         rdata_reg <= 32'h0000_0000;
      end else begin
         ctrl_reg  <= ctrl_next;
         wpend_reg <= wpend_next;
         waddr_reg <= waddr_next;
         rdata_reg <= rdata_next;
      end
   end

   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign hrdata    = rdata_reg;

   // power state, dll and refresh bookkeeping
   always_comb begin
      state_next = state_reg;
      dll_next   = dll_reg;
      idle_next  = idle_reg;
      rfc_next   = (rfc_reg != 8'h00) ? 8'(rfc_reg - 8'h01) : 8'h00;
      xsnr_next  = xsnr_reg;
      trefi_next = trefi_reg;
      refc_next  = refc_reg;
      selfc_next = selfc_reg;
      if (rfc_reg == 8'h01) begin
         idle_next = 1'b1; // [R10]
      end
      case (state_reg)
         ST_RUN: begin
            case (kind)
               C_SRE: begin
                  state_next = ST_SREF;
                  dll_next   = 1'b0; // [R3]
                  trefi_next = 12'(`DDRRF_TREFI_CYC - 1);
               end
               C_REF: begin
                  rfc_next  = 8'(`DDRRF_TRFC_CYC); // [R10]
                  idle_next = 1'b0;
                  refc_next = 16'(refc_reg + 16'h0001);
               end
               C_ACT: idle_next = 1'b0;
               C_PRE: idle_next = cmd.addr[10] ? 1'b1 : idle_reg;
               default: ; // [R14]
            endcase
         end
         ST_SREF: begin
            // internal timer keeps the array alive; only cke is looked at, the other pins are not
            trefi_next = (trefi_reg == 12'h000) ? 12'(`DDRRF_TREFI_CYC - 1) :
                         12'(trefi_reg - 12'h001);
            if (trefi_reg == 12'h000) begin
               selfc_next = 16'(selfc_reg + 16'h0001);
            end
            if (cmd.cke) begin // [R1]
               state_next = ST_EXIT;
               dll_next   = 1'b1; // [R3]
               xsnr_next  = 8'(`DDRRF_TXSNR_CYC);
            end
         end
         ST_EXIT: begin
            // commands stay ignored until the exit delay in xsnr_reg has counted down
            xsnr_next = 8'(xsnr_reg - 8'h01);
            if (xsnr_reg == 8'h01) begin
               state_next = ST_RUN;
            end
         end
         default: state_next = ST_RUN;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_reg <= ST_RUN;
         dll_reg   <= 1'b1;
         idle_reg  <= 1'b1;
         rfc_reg   <= 8'h00;
         xsnr_reg  <= 8'h00;
         trefi_reg <= 12'h000;
         refc_reg  <= 16'h0000;
         selfc_reg <= 16'h0000;
      end else begin
         state_reg <= state_next;
         dll_reg   <= dll_next;
         idle_reg  <= idle_next;
         rfc_reg   <= rfc_next;
         xsnr_reg  <= xsnr_next;
         trefi_reg <= trefi_next;
         refc_reg  <= refc_next;
         selfc_reg <= selfc_next;
      end
   end

   assign self_refresh = state_reg == ST_SREF;
   assign dll_on       = dll_reg;
   assign refresh_busy = rfc_reg != 8'h00;
   assign banks_idle   = idle_reg;
   assign odt_active   = cmd.odt && state_reg == ST_RUN;

   // column commands shift along; the tap picks the execution moment
   always_comb begin
      line_next[0].valid = state_reg == ST_RUN && (kind == C_RD || kind == C_WR); // [R18]
      line_next[0].wr    = kind == C_WR;
      line_next[0].col   = cmd.addr[8:0];
      for (int i = 1; i < `DDRRF_LINE_DEPTH; i++) begin
         line_next[i] = line_reg[i];
         line_next[i] = line_reg[i-1];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         for (int i = 0; i < `DDRRF_LINE_DEPTH; i++) begin
            line_reg[i] <= '0;
         end
      end else begin
         for (int i = 0; i < `DDRRF_LINE_DEPTH; i++) begin
            line_reg[i] <= line_next[i];
         end
      end
   end

   // read taps at rl-1, write at rl-2, so the first beat shows rl or wl later
   ddrrf_ent_t rd_tap;
   ddrrf_ent_t wr_tap;
   logic       seq_start;
   assign rd_tap    = line_reg[4'(cfg_rl - 4'h1)];
   assign wr_tap    = line_reg[4'(cfg_rl - 4'h2)];
   assign seq_start = (rd_tap.valid && !rd_tap.wr) || (wr_tap.valid && wr_tap.wr); // [R19]

   ddrrf_colseq u_colseq (
      .hclk       (hclk),
      .hresetn    (hresetn),
      .start      (seq_start),
      .start_wr   (wr_tap.valid && wr_tap.wr),
      .start_col  ((wr_tap.valid && wr_tap.wr) ? wr_tap.col : rd_tap.col),
      .bl8        (cfg_bl8),
      .ilv        (cfg_ilv),
      .beat_valid (beat_valid),
      .beat_wr    (beat_wr),
      .beat_col0  (beat_col0),
      .beat_col1  (beat_col1)
   );

   a_sref_entry: assert property (@(posedge hclk) disable iff (!hresetn) // [R3]
      (state_reg == ST_RUN && kind == C_SRE) |=> (self_refresh && !dll_on))
      else $error("self refresh entry did not stop the dll");

   a_sref_exit: assert property (@(posedge hclk) disable iff (!hresetn) // [R3]
      (state_reg == ST_SREF && cmd.cke) |=> (dll_on && state_reg == ST_EXIT))
      else $error("self refresh exit did not restart the dll");

   a_sref_hold: assert property (@(posedge hclk) disable iff (!hresetn) // [R1]
      (state_reg == ST_SREF && !cmd.cke) |=> (state_reg == ST_SREF && $stable(idle_reg)))
      else $error("self refresh left while cke low");

   a_sref_nocol: assert property (@(posedge hclk) disable iff (!hresetn) // [R1]
      (state_reg != ST_RUN) |=> !line_reg[0].valid)
      else $error("column command taken outside normal operation");

   a_ref_idle: assert property (@(posedge hclk) disable iff (!hresetn) // [R10]
      (state_reg == ST_RUN && kind == C_REF) |=> refresh_busy ##[1:RFC_A] banks_idle)
      else $error("refresh did not leave banks idle");

   a_nop_still: assert property (@(posedge hclk) disable iff (!hresetn) // [R14]
      (state_reg == ST_RUN && (kind == C_NOP || kind == C_DESEL) && rfc_reg == 8'h00)
         |=> ($stable(idle_reg) && $stable(refc_reg) && state_reg == ST_RUN))
      else $error("nop or deselect changed state");

   a_read_lat: assert property (@(posedge hclk) disable iff (!hresetn) // [R19]
      (state_reg == ST_RUN && kind == C_RD && cfg_al == 3'h0 && cfg_cl == 3'h3 &&
       $stable(ctrl_reg)) |-> ##4 (beat_valid && !beat_wr))
      else $error("read data not at read latency");

   a_write_lat: assert property (@(posedge hclk) disable iff (!hresetn) // [R19]
      (state_reg == ST_RUN && kind == C_WR && cfg_al == 3'h2 && cfg_cl == 3'h3 &&
       $stable(ctrl_reg)) |-> ##5 (beat_valid && beat_wr))
      else $error("write data not at write latency");

endmodule

`default_nettype wire

// ==== verification/ddrrf_ctrl_model.sv ====
/*
  Controller model driving the command pins of the refresh and burst core.
  Assumes a free running hclk; the bench calls issue() hierarchically.
*/
`timescale 1ns/100ps
`default_nettype none

module ddrrf_ctrl_model
   import ddrrf_pkg::*;
(
   input  wire logic       hclk,
   output var ddrrf_cmd_t  cmd
);
   // idle pins: deselected, termination off, cke high
   initial begin
      cmd = '1;
      cmd.odt = 1'b0;
   end

   // one command for one edge, then deselect with inverted strobes and address
   // clock never stopped, which entry allows
   // callers space refresh, exit and column commands
   task automatic issue(input logic [3:0] csrcw, input logic cke, input logic [14:0] ba_addr);
      ddrrf_cmd_t c;
      c = {csrcw, cke, 1'b0, ba_addr}; // odt low before every command
      @(posedge hclk);
      cmd <= c;
      @(posedge hclk);
      c = ~c;
      c.cs_n = 1'b1;
      c.odt = 1'b0;
      c.cke = cke; // filler keeps cke: low holds self refresh, high exits with deselect
      cmd <= c;
   endtask
endmodule

`default_nettype wire

// ==== verification/ddrrf_top_test.sv ====
/*
  Self-checking bench of the refresh and burst core over AHB-Lite and the command pins.
  Assumes the controller model beside it and a 100 MHz hclk.
*/
`timescale 1ns/100ps
`default_nettype none

`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin mismatches++; \
   $display("unexpected at %0t: got %h expected %h", $time, (g), (e)); end end

module ddrrf_top_test
   import ddrrf_pkg::*;
;
   logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
   logic [1:0]  htrans = 2'h0;
   logic [2:0]  hsize = 3'h2;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, d;
   logic        hreadyout, hresp, self_refresh, dll_on, refresh_busy, banks_idle, odt_active;
   logic        beat_valid, beat_wr;
   logic [8:0]  beat_col0, beat_col1;
   ddrrf_cmd_t  cmd;
   int          mismatches = 0, checks_done = 0, cycles = 0;
   logic [10:0] cfg [9] = '{11'h032, 11'h03a, 11'h233, 11'h63b, 11'h503, 11'h722, 11'h13a, 11'h332, 11'h43b};
   logic [8:0]  cols [9] = '{9'h005, 9'h1ff, 9'h0d5, 9'h0a3, 9'h007, 9'h0e2, 9'h151, 9'h00b, 9'h1fe};

   ddrrf_top ddrrf_top_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .cmd(cmd),
      .self_refresh(self_refresh), .dll_on(dll_on), .refresh_busy(refresh_busy),
      .banks_idle(banks_idle), .odt_active(odt_active), .beat_valid(beat_valid),
      .beat_wr(beat_wr), .beat_col0(beat_col0), .beat_col1(beat_col1));
   ddrrf_ctrl_model ddrrf_ctrl_model_i (.hclk(hclk), .cmd(cmd));

   // clock, and a ceiling well above the thousand or so cycles the scenarios need
   always #5 hclk = ~hclk;
   always @(posedge hclk) begin
      cycles++;
      if (cycles == 20000) begin
         mismatches++;
         tally_and_finish();
      end
   end

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   // single word transfer; waits on hready, read data taken at the data phase edge
   task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= wr;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask

   // beat column worked out from the burst tables, not from shared code
   function automatic logic [8:0] exp_col(logic [8:0] s, int i, logic bl8, logic ilv);
      logic [2:0] k;
      k = i[2:0];
      if (ilv) return bl8 ? {s[8:3], s[2:0] ^ k} : {s[8:2], s[1:0] ^ k[1:0]};
      return {s[8:3], bl8 ? s[2] ^ k[2] : s[2], 2'(s[1:0] + k[1:0])};
   endfunction

   // reset values, masking, read-only and unmapped places
   task automatic t_regs();
      `CHK({dll_on, banks_idle, self_refresh}, 3'h6)
      ahb(1'b0, 8'h00, 32'h0, d); `CHK(d, 32'h032)
      ahb(1'b0, 8'h04, 32'h0, d); `CHK(d, 32'h00c)
      ahb(1'b1, 8'h00, 32'hffffffff, d);
      ahb(1'b1, 8'h04, 32'hffffffff, d);
      ahb(1'b0, 8'h00, 32'h0, d); `CHK(d, 32'h77f)
      ahb(1'b0, 8'h04, 32'h0, d); `CHK(d, 32'h00c)
      ahb(1'b0, 8'h0c, 32'h0, d); `CHK(d, 32'h0)
   endtask

   // one posted burst: latency, length, direction and beat order
   task automatic t_burst(input logic [10:0] c, input logic wr, input logic [8:0] col);
      int al, cl, lat, n;
      logic bl8;
      al = (c[10:8] == 3'h7) ? 6 : c[10:8];
      cl = (c[6:4] < 3'h2) ? 2 : c[6:4];
      lat = wr ? al + cl - 1 : al + cl;
      bl8 = (c[2:0] == 3'h3);
      n = bl8 ? 4 : 2;
      ahb(1'b1, 8'h00, {21'h0, c}, d);
      ddrrf_ctrl_model_i.issue(wr ? 4'h4 : 4'h5, 1'b1, {6'h15, col});
      repeat (lat - 1) @(posedge hclk);
      #1 `CHK(beat_valid, 1'b0)
      for (int k = 0; k < n; k++) begin
         @(posedge hclk);
         #1 `CHK({beat_valid, beat_wr}, {1'b1, wr})
         `CHK(beat_col0, exp_col(col, 2 * k, bl8, c[3]))
         `CHK(beat_col1, exp_col(col, 2 * k + 1, bl8, c[3]))
      end
      @(posedge hclk);
      #1 `CHK(beat_valid, 1'b0)
   endtask

   // activate, ignored deselect and nop, then one refresh with don't-care address
   task automatic t_refresh();
      logic [31:0] n0;
      ahb(1'b0, 8'h08, 32'h0, n0);
      ddrrf_ctrl_model_i.issue(4'h3, 1'b1, 15'h1234);
      #1 `CHK(banks_idle, 1'b0)
      ddrrf_ctrl_model_i.issue(4'h9, 1'b1, 15'h0);
      ddrrf_ctrl_model_i.issue(4'h7, 1'b1, 15'h0);
      ddrrf_ctrl_model_i.issue(4'h1, 1'b1, 15'h7fff);
      @(posedge hclk);
      #1 `CHK({refresh_busy, banks_idle}, 2'h2)
      repeat (9) @(posedge hclk);
      #1 `CHK(refresh_busy, 1'b1)
      @(posedge hclk);
      #1 `CHK({refresh_busy, banks_idle}, 2'h1)
      ahb(1'b0, 8'h08, 32'h0, d); `CHK(d[15:0], 16'(n0[15:0] + 1))
   endtask

   // entry, pins ignored while held, internal ticks, exit window, refresh after
   task automatic t_sref();
      logic [31:0] n0;
      logic [15:0] dt;
      ahb(1'b0, 8'h08, 32'h0, n0);
      ddrrf_ctrl_model_i.issue(4'h1, 1'b0, 15'h0);
      @(posedge hclk);
      #1 `CHK({self_refresh, dll_on}, 2'h2)
      ddrrf_ctrl_model_i.issue(4'h5, 1'b0, 15'h0);
      repeat (790) @(posedge hclk);
      ahb(1'b0, 8'h08, 32'h0, d);
      dt = d[31:16] - n0[31:16];
      `CHK({d[15:0] == n0[15:0], dt == 16'h1 || dt == 16'h2}, 2'h3)
      ddrrf_ctrl_model_i.issue(4'h7, 1'b1, 15'h0);
      @(posedge hclk);
      #1 `CHK({self_refresh, dll_on}, 2'h1)
      repeat (12) @(posedge hclk);
      #1 `CHK(self_refresh, 1'b0)
      ddrrf_ctrl_model_i.issue(4'h1, 1'b1, 15'h0);
      repeat (12) @(posedge hclk);
      ahb(1'b0, 8'h04, 32'h0, d); `CHK(d, 32'h00c)
   endtask

   initial begin
      repeat (20) @(posedge hclk);
      hresetn <= 1'b1;
      t_regs();
      for (int i = 0; i < 9; i++) t_burst(cfg[i], i[0], cols[i]);
      t_refresh();
      t_sref();
      tally_and_finish();
   end
endmodule

`default_nettype wire
